//--- shared/dram_cfg.svh
// Timing and geometry constants for the page-mode memory controller
`ifndef DRAM_CFG_SVH
`define DRAM_CFG_SVH

// System clock rate
`define CLK_MHZ 100
// Start-up pause and wake-up refresh count
`define POWER_UP_US 200
`define POWER_UP_CYC (`POWER_UP_US * `CLK_MHZ)
`define WAKE_REFRESHES 8
// Refresh geometry: rows per refresh period, period in ms
`define REFRESH_ROWS 512
`define REFRESH_PERIOD_MS 8
`define REF_INTERVAL_NS (`REFRESH_PERIOD_MS * 1000000 / `REFRESH_ROWS)
`define REF_INTERVAL_CYC (`REF_INTERVAL_NS * `CLK_MHZ / 1000)
// Strobe precharge (least time, rounded up)
`define PRECHARGE_NS 40
`define PRECHARGE_CYC ((`PRECHARGE_NS * `CLK_MHZ + 999) / 1000)
// Row strobe to column strobe delay (least)
`define ROW_TO_COL_NS 20
`define ROW_TO_COL_CYC ((`ROW_TO_COL_NS * `CLK_MHZ + 999) / 1000)
// Strobe low time covering row strobe width and access time
`define ACCESS_NS 60
`define ACCESS_CYC ((`ACCESS_NS * `CLK_MHZ + 999) / 1000)
// Column strobe setup before row strobe in strobe-first refresh
`define REFRESH_STROBE_SETUP_NS 10
`define REFRESH_STROBE_SETUP_CYC ((`REFRESH_STROBE_SETUP_NS * `CLK_MHZ + 999) / 1000)
// Column strobe hold after row strobe in strobe-first refresh
`define REFRESH_STROBE_HOLD_NS 10
`define REFRESH_STROBE_HOLD_CYC ((`REFRESH_STROBE_HOLD_NS * `CLK_MHZ + 999) / 1000)
// Longest row strobe low time in page mode (longest, rounded down)
`define PAGE_ROW_STROBE_WIDTH_NS 100000
`define PAGE_ROW_STROBE_WIDTH_CYC (`PAGE_ROW_STROBE_WIDTH_NS * `CLK_MHZ / 1000)
// Address split
`define ROW_LSB 9
`define ADDR_W 9

`endif

//--- shared/dram_pkg.sv
// Types shared by the memory controller modules
package dram_pkg;

    // Controller states, one-hot
    typedef enum logic [7:0] {
        ST_POWERUP   = 8'h01,
        ST_IDLE      = 8'h02,
        ST_ROW       = 8'h04,
        ST_COL       = 8'h08,
        ST_ACCESS    = 8'h10,
        ST_PRECHARGE = 8'h20,
        ST_REF_SETUP = 8'h40,
        ST_REF_RAS   = 8'h80
    } ctrl_st_t;

    // Controller state record
    typedef struct packed {
        ctrl_st_t st;
        logic [15:0] cnt;
        logic [3:0] wake_left;
        logic ras_n;
        logic lower_byte_column_strobe_n;
        logic upper_byte_column_strobe_n;
        logic we_n;
        logic oe_n;
        logic [8:0] addr;
        logic [8:0] col;
        logic [1:0] lanes;
        logic write;
        logic [15:0] dq_out;
        logic dq_oe;
        logic [15:0] rdata;
        logic ack;
        logic init_done;
        logic served;
        logic clr_ovd;
    } ctrl_state_t;

    // Refresh timer state record
    typedef struct packed {
        logic [15:0] cnt;
        logic due;
        logic overdue;
    } timer_state_t;

endpackage : dram_pkg

//--- shared/refresh_if.sv
// Link between the controller and its refresh interval timer
`timescale 1ns/1ps
`default_nettype none
interface refresh_if;
    logic due;
    logic overdue;
    logic served;
    logic clear_overdue;
    modport timer (input served, input clear_overdue, output due, output overdue);
    modport ctrl (output served, output clear_overdue, input due, input overdue);
endinterface : refresh_if
`default_nettype wire

//--- hdl/refresh_timer.sv
// Refresh interval timer: raises due each row interval, overdue if missed
`timescale 1ns/1ps
`default_nettype none
`include "dram_cfg.svh"
module refresh_timer
    import dram_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Controller side
    refresh_if.timer rif
);
    timer_state_t q;
    timer_state_t next_q;
    logic tick;

    // Interval count and sticky flags; a new tick wins over a clear
    always_comb begin
        next_q = q;
        tick = (q.cnt == 16'(`REF_INTERVAL_CYC - 1));
        next_q.cnt = tick ? 16'h0000 : q.cnt + 16'h0001;
        if (rif.served) begin
            next_q.due = 1'b0;
        end
        if (rif.clear_overdue) begin
            next_q.overdue = 1'b0;
        end
        if (tick) begin
            next_q.due = 1'b1;
            if (q.due && !rif.served) begin
                next_q.overdue = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign rif.due = q.due;
    assign rif.overdue = q.overdue;
endmodule : refresh_timer
`default_nettype wire

//--- hdl/dram_ctrl.sv
// Host controller for an asynchronous 16-bit page-mode dynamic memory
// Memory rules behind this block
// - Wait 200 us after start, then run eight refresh cycles before use.
// - Rerun the eight-cycle wake-up whenever a refresh interval was missed.
// - Refresh all 512 rows within every 8 ms period.
// - Raise both strobes for the precharge time to start a fresh cycle.
// - Keep write enable high through a read until the strobes rise.
// - Time write enable as early write or read-write, never between.
// - Never hold output enable low permanently; keep it high in writes.
// - A write command is the falling edge of write enable.
// - Keep output enable high during the write phase of a write.
// - Row strobe low no longer than 100K ns; column accesses spaced.
// - Page read-write accesses spaced by the page read-write cycle time.
// - Strobe-first refresh: column strobe low before and after row strobe fall.
// - Hidden refresh needs output enable set up by the row strobe fall.
`timescale 1ns/1ps
`default_nettype none
`include "dram_cfg.svh"
module dram_ctrl
    import dram_pkg::*;
#(
    parameter logic [15:0] POWER_UP_CYC = 16'(`POWER_UP_CYC)
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // User request
    input wire logic req,
    input wire logic req_write,
    input wire logic [17:0] req_addr,
    input wire logic [15:0] req_wdata,
    input wire logic [1:0] req_byte_en,
    // User answer
    output logic ack,
    output logic [15:0] rdata,
    output logic init_done,
    // Memory pins
    output logic ras_n,
    output logic lower_byte_column_strobe_n,
    output logic upper_byte_column_strobe_n,
    output logic we_n,
    output logic oe_n,
    output logic [8:0] addr,
    input wire logic [15:0] dq_in,
    output logic [15:0] dq_out,
    output logic dq_oe
);
    ctrl_state_t q;
    ctrl_state_t next_q;
    refresh_if rif();

    refresh_timer u_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .rif(rif)
    );

    // Sequencer: wake-up, refresh, single random accesses
    always_comb begin
        next_q = q;
        next_q.cnt = q.cnt + 16'h0001;
        next_q.ack = 1'b0;
        next_q.served = 1'b0;
        next_q.clr_ovd = 1'b0;
        case (q.st)
            ST_POWERUP: begin
                if (q.cnt >= POWER_UP_CYC - 16'h0001) begin
                    next_q.wake_left = 4'(`WAKE_REFRESHES);
                    next_q.st = ST_IDLE;
                end
            end
            ST_IDLE: begin
                next_q.cnt = 16'h0000;
                if (rif.overdue) begin
                    next_q.wake_left = 4'(`WAKE_REFRESHES);
                    next_q.clr_ovd = 1'b1;
                end else if (q.wake_left != 4'h0 || rif.due) begin
                    next_q.lower_byte_column_strobe_n = 1'b0;
                    next_q.upper_byte_column_strobe_n = 1'b0;
                    // Output enable settled high well before the row strobe falls
                    next_q.oe_n = 1'b1;
                    next_q.st = ST_REF_SETUP;
                end else if (req) begin
                    next_q.addr = req_addr[17:9];
                    next_q.col = req_addr[8:0];
                    next_q.write = req_write;
                    next_q.lanes = (req_write && req_byte_en != 2'h0) ? req_byte_en : 2'h3;
                    next_q.dq_out = req_wdata;
                    next_q.st = ST_ROW;
                end
            end
            ST_ROW: begin
                next_q.ras_n = 1'b0;
                if (q.cnt == 16'(`ROW_TO_COL_CYC)) begin
                    next_q.addr = q.col;
                    next_q.we_n = !q.write;
                    next_q.oe_n = q.write;
                    next_q.dq_oe = q.write;
                    next_q.st = ST_COL;
                end
            end
            ST_COL: begin
                // Write enable already low: early write
                next_q.lower_byte_column_strobe_n = !q.lanes[0];
                next_q.upper_byte_column_strobe_n = !q.lanes[1];
                next_q.cnt = 16'h0000;
                next_q.st = ST_ACCESS;
            end
            ST_ACCESS: begin
                if (q.cnt == 16'(`ACCESS_CYC - 1)) begin
                    if (!q.write) begin
                        next_q.rdata = dq_in;
                    end
                    next_q.ack = 1'b1;
                    // One column access per row cycle, so page spacing is always met
                    next_q.ras_n = 1'b1;
                    next_q.lower_byte_column_strobe_n = 1'b1;
                    next_q.upper_byte_column_strobe_n = 1'b1;
                    next_q.we_n = 1'b1;
                    next_q.oe_n = 1'b1;
                    next_q.dq_oe = 1'b0;
                    next_q.cnt = 16'h0000;
                    next_q.st = ST_PRECHARGE;
                end
            end
            ST_PRECHARGE: begin
                if (q.cnt == 16'(`PRECHARGE_CYC - 1)) begin
                    next_q.st = ST_IDLE;
                end
            end
            ST_REF_SETUP: begin
                if (q.cnt == 16'(`REFRESH_STROBE_SETUP_CYC - 1)) begin
                    next_q.ras_n = 1'b0;
                    next_q.cnt = 16'h0000;
                    next_q.st = ST_REF_RAS;
                end
            end
            ST_REF_RAS: begin
                // Row strobe width exceeds the column strobe hold
                if (q.cnt == 16'(`ACCESS_CYC - 1)) begin
                    next_q.ras_n = 1'b1;
                    next_q.lower_byte_column_strobe_n = 1'b1;
                    next_q.upper_byte_column_strobe_n = 1'b1;
                    next_q.served = 1'b1;
                    if (q.wake_left != 4'h0) begin
                        next_q.wake_left = q.wake_left - 4'h1;
                        next_q.init_done = (q.wake_left == 4'h1) | q.init_done;
                    end
                    next_q.cnt = 16'h0000;
                    next_q.st = ST_PRECHARGE;
                end
            end
            default: begin
                next_q.st = ST_IDLE;
            end
        endcase
    end

    // State register with idle pin levels at reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.st <= ST_POWERUP;
            q.ras_n <= 1'b1;
            q.lower_byte_column_strobe_n <= 1'b1;
            q.upper_byte_column_strobe_n <= 1'b1;
            q.we_n <= 1'b1;
            q.oe_n <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    // Outputs straight from the state register
    assign rif.served = q.served;
    assign rif.clear_overdue = q.clr_ovd;
    assign ack = q.ack;
    assign rdata = q.rdata;
    assign init_done = q.init_done;
    assign ras_n = q.ras_n;
    assign lower_byte_column_strobe_n = q.lower_byte_column_strobe_n;
    assign upper_byte_column_strobe_n = q.upper_byte_column_strobe_n;
    assign we_n = q.we_n;
    assign oe_n = q.oe_n;
    assign addr = q.addr;
    assign dq_out = q.dq_out;
    assign dq_oe = q.dq_oe;

    // Helper counters for the checks
    logic [15:0] boot_cnt;
    logic [15:0] ras_low_cnt;
    logic [15:0] ref_gap;
    logic ref_row_low;
    // First cycle of the row strobe low phase of a refresh
    assign ref_row_low = (q.st == ST_REF_RAS) && (q.cnt == 16'h0000);
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            boot_cnt <= 16'h0000;
            ras_low_cnt <= 16'h0000;
            ref_gap <= 16'h0000;
        end else begin
            boot_cnt <= (boot_cnt == 16'hffff) ? boot_cnt : boot_cnt + 16'h0001;
            ras_low_cnt <= q.ras_n ? 16'h0000 : ras_low_cnt + 16'h0001;
            ref_gap <= (q.served || !q.init_done) ? 16'h0000 : ref_gap + 16'h0001;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    AST_POWER_UP_WAIT: assert property ($fell(ras_n) |-> boot_cnt >= POWER_UP_CYC)
        else $error("row strobe fell before power-up pause");
    AST_REFRESH_SPACING: assert property (ref_gap <= 16'(`REF_INTERVAL_CYC * 2))
        else $error("refresh interval exceeded");
    AST_PRECHARGE: assert property ($rose(ras_n) |-> (ras_n && lower_byte_column_strobe_n
        && upper_byte_column_strobe_n) [*4])
        else $error("precharge shorter than four cycles");
    AST_READ_HOLD: assert property (!oe_n |-> we_n)
        else $error("write enable low during a read");
    AST_EARLY_WRITE: assert property ($fell(lower_byte_column_strobe_n) && !we_n
        && !ras_n |-> $past(!we_n))
        else $error("write enable not ahead of column strobe");
    AST_OE_HIGH_IN_WRITE: assert property (!we_n |-> oe_n && dq_oe)
        else $error("output enable low during write");
    AST_RAS_WIDTH: assert property (ras_low_cnt < 16'(`PAGE_ROW_STROBE_WIDTH_CYC))
        else $error("row strobe held low too long");
    AST_STROBE_FIRST_SETUP: assert property ($fell(ras_n) && !lower_byte_column_strobe_n
        |-> $past(!lower_byte_column_strobe_n) ##1 !lower_byte_column_strobe_n)
        else $error("strobe-first refresh setup or hold violated");
    AST_ROW_ADDR_HOLD: assert property ($fell(ras_n) |=> $stable(addr))
        else $error("row address changed at row strobe fall");
    AST_COL_ADDR: assert property ($fell(upper_byte_column_strobe_n) && we_n && !ras_n
        |-> $stable(addr) && !oe_n)
        else $error("column address unstable at column strobe fall");

    COV_READ: cover property (ack && we_n && !q.write);
    COV_WRITE: cover property ($fell(we_n) ##[1:12] ack);
    COV_REFRESH: cover property (ref_row_low ##[1:10] q.served);
    COV_WAKE: cover property ($rose(init_done));
endmodule : dram_ctrl
`default_nettype wire

//--- sim/dram_mem_model.sv
// Behavioural page-mode memory driven through its pins
`timescale 1ns/1ps
`default_nettype none
module dram_mem_model (
    // Strobes and enables
    input wire logic ras_n,
    input wire logic lower_byte_column_strobe_n,
    input wire logic upper_byte_column_strobe_n,
    input wire logic we_n,
    input wire logic oe_n,
    // Address and data
    input wire logic [8:0] addr,
    input wire logic [15:0] dq_out,
    output logic [15:0] dq_in,
    // Counts seen by the bench
    output int refresh_count,
    output int access_count,
    output int model_err
);
    wire logic lcs_n = lower_byte_column_strobe_n;
    wire logic ucs_n = upper_byte_column_strobe_n;
    logic [15:0] mem [int];
    logic [8:0] row = 9'h000;
    logic [15:0] rd = 16'h0000;
    logic strobe_first = 1'b0;
    realtime t_up = 0.0;
    realtime t_dn = 0.0;
    realtime t_col = 0.0;
    int k;
    logic [15:0] w;

    // Counters start clear
    initial begin
        refresh_count = 0;
        access_count = 0;
        model_err = 0;
    end

    // Row latch, strobe-first refresh and precharge checks
    always @(negedge ras_n) begin
        if ($realtime - t_up < 40.0) model_err++;
        t_dn = $realtime;
        strobe_first = !lcs_n || !ucs_n;
        if (strobe_first) begin
            refresh_count++;
            if ($realtime - t_col < 10.0) model_err++;
        end else begin
            row = addr;
        end
    end

    // Row strobe width limit
    always @(posedge ras_n) begin
        if ($realtime - t_dn > 100000.0) model_err++;
        t_up = $realtime;
    end

    // Column strobe hold in strobe-first refresh
    always @(posedge lcs_n or posedge ucs_n) begin
        if (strobe_first && $realtime - t_dn < 10.0) model_err++;
    end

    // Late write enable is never expected from this host
    always @(negedge we_n) begin
        if (!lcs_n || !ucs_n) model_err++;
    end

    // Column access: early write per lane, or fetch read word
    always @(negedge lcs_n or negedge ucs_n) begin
        t_col = $realtime;
        if (!ras_n) begin
            access_count++;
            k = int'({row, addr});
            w = mem.exists(k) ? mem[k] : ~k[15:0];
            if (!we_n) begin
                if (!lcs_n) w[7:0] = dq_out[7:0];
                if (!ucs_n) w[15:8] = dq_out[15:8];
                mem[k] = w;
            end else begin
                rd = w;
            end
        end
    end

    // Selected lanes drive read data, released lanes show the inverse
    always_comb begin
        dq_in = ~rd;
        if (!ras_n && we_n && !oe_n) begin
            if (!lcs_n) dq_in[7:0] = rd[7:0];
            if (!ucs_n) dq_in[15:8] = rd[15:8];
        end
    end
endmodule : dram_mem_model
`default_nettype wire

//--- sim/dram_ctrl_tb_top.sv
// Self-checking bench for the page-mode memory controller
`timescale 1ns/1ps
`default_nettype none
`include "dram_cfg.svh"
module dram_ctrl_tb_top;
    import dram_pkg::*;
    localparam logic [15:0] PU = 16'h0032;
    localparam int LIMIT = 20000;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic req = 1'b0;
    logic req_write = 1'b0;
    logic [17:0] req_addr = 18'h0_0000;
    logic [15:0] req_wdata = 16'h0000;
    logic [1:0] req_byte_en = 2'h0;
    logic ack, init_done, ras_n, lcs_n, ucs_n, we_n, oe_n, dq_oe;
    logic [15:0] rdata, dq_in, dq_out, got;
    logic [8:0] addr;
    int refresh_count, access_count, model_err;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    int ack_at = 0;

    // Clock
    always #5 clk_sys = ~clk_sys;

    dram_ctrl #(.POWER_UP_CYC(PU)) u_dram_ctrl (.clk_sys(clk_sys), .rst(rst), .req(req),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_byte_en(req_byte_en), .ack(ack), .rdata(rdata), .init_done(init_done),
        .ras_n(ras_n), .lower_byte_column_strobe_n(lcs_n), .upper_byte_column_strobe_n(ucs_n),
        .we_n(we_n), .oe_n(oe_n), .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));

    dram_mem_model u_dram_mem_model (.ras_n(ras_n), .lower_byte_column_strobe_n(lcs_n),
        .upper_byte_column_strobe_n(ucs_n), .we_n(we_n), .oe_n(oe_n), .addr(addr),
        .dq_out(dq_out), .dq_in(dq_in), .refresh_count(refresh_count),
        .access_count(access_count), .model_err(model_err));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    // Hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_mismatch++;
            $display("[ERR] %0t run too long", $time);
            tally_and_finish();
        end
    end

    task automatic chk16(input logic [15:0] g, input logic [15:0] e, input string m);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %0t %s got %h want %h", $time, m, g, e);
        end
    endtask : chk16

    task automatic chk_int(input int g, input int e, input string m);
        check_count++;
        if (g != e) begin
            n_mismatch++;
            $display("[ERR] %0t %s got %0d want %0d", $time, m, g, e);
        end
    endtask : chk_int

    // Wait for the one-cycle acknowledge, then release the request
    task automatic wait_ack(output logic [15:0] r);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (ack !== 1'b1 && n < 600);
        r = rdata;
        ack_at = cyc;
        req = 1'b0;
        chk_int(int'(n < 600), 1, "no ack");
    endtask : wait_ack

    task automatic access(input logic w, input logic [17:0] a, input logic [15:0] d,
            input logic [1:0] be, output logic [15:0] r);
        @(posedge clk_sys);
        #1;
        req = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        req_byte_en = be;
        wait_ack(r);
    endtask : access

    task automatic test_wake();
        int n;
        int early;
        n = 0;
        early = -1;
        // Pins settle at the first edge under reset
        @(posedge clk_sys);
        #1;
        chk16({8'h00, ras_n, lcs_n, ucs_n, we_n, oe_n, dq_oe, ack, init_done},
            16'h00F8, "reset pins");
        req = 1'b1;
        req_write = 1'b1;
        req_addr = 18'h0_0105;
        req_wdata = 16'h3C5A;
        req_byte_en = 2'h0;
        repeat (11) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        while (init_done !== 1'b1 && n < 400) begin
            @(posedge clk_sys);
            #1;
            n++;
            if (n == int'(PU) - 1) early = refresh_count;
        end
        chk_int(early, 0, "refresh in pause");
        chk_int(refresh_count, 8, "wake refreshes");
        chk_int(access_count, 0, "access before ready");
        chk_int(int'(init_done === 1'b1), 1, "ready flag");
        wait_ack(got);
        access(1'b0, 18'h0_0105, 16'h0000, 2'h0, got);
        chk16(got, 16'h3C5A, "held request");
        $display("test wake done");
    endtask : test_wake

    task automatic test_rows();
        logic [17:0] a [4] = '{18'h0_0003, 18'h0_0203, 18'h3_FE03, 18'h0_0004};
        for (int i = 0; i < 4; i++) access(1'b1, a[i], 16'h5A00 + 16'(i), 2'h3, got);
        for (int i = 0; i < 4; i++) begin
            access(1'b0, a[i], 16'h0000, 2'h0, got);
            chk16(got, 16'h5A00 + 16'(i), "row column word");
        end
        $display("test rows done");
    endtask : test_rows

    task automatic test_lanes();
        access(1'b1, 18'h0_1111, 16'hA1B2, 2'h3, got);
        access(1'b1, 18'h0_1111, 16'hFFC3, 2'h1, got);
        access(1'b0, 18'h0_1111, 16'h0000, 2'h0, got);
        chk16(got, 16'hA1C3, "low lane");
        access(1'b1, 18'h0_1111, 16'hD4FF, 2'h2, got);
        access(1'b0, 18'h0_1111, 16'h0000, 2'h0, got);
        chk16(got, 16'hD4C3, "high lane");
        access(1'b1, 18'h0_1111, 16'h6789, 2'h0, got);
        access(1'b0, 18'h0_1111, 16'h0000, 2'h0, got);
        chk16(got, 16'h6789, "both lanes");
        $display("test lanes done");
    endtask : test_lanes

    task automatic test_back_to_back();
        int first;
        access(1'b0, 18'h0_0203, 16'h0000, 2'h0, got);
        first = ack_at;
        access(1'b0, 18'h3_FE03, 16'h0000, 2'h0, got);
        chk16(got, 16'h5A02, "second read");
        // Ten cycles take to answer, four of precharge, one idle before the next take
        chk_int(ack_at - first, 15, "ack spacing");
        $display("test back to back done");
    endtask : test_back_to_back

    task automatic test_refresh_rate();
        int c0;
        repeat (30) @(posedge clk_sys);
        #1;
        c0 = refresh_count;
        repeat (3 * `REF_INTERVAL_CYC) @(posedge clk_sys);
        #1;
        chk_int(refresh_count - c0, 3, "refreshes per window");
        chk_int(model_err, 0, "pin timing");
        $display("test refresh rate done");
    endtask : test_refresh_rate

    // Main sequence
    initial begin
        test_wake();
        test_rows();
        test_lanes();
        test_back_to_back();
        test_refresh_rate();
        tally_and_finish();
    end
endmodule : dram_ctrl_tb_top
`default_nettype wire
